// ### rtl/dual_timer_pkg.sv
// constants for the dual interval timer control block
package dual_timer_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 4;
	localparam logic [3:0] IRQ_STATUS = 4'h0;
	localparam logic [3:0] IRQ_MASK = 4'h1;
	localparam logic [3:0] TA_LO = 4'h4;
	localparam logic [3:0] TA_HI = 4'h5;
	localparam logic [3:0] TB_LO = 4'h6;
	localparam logic [3:0] TB_HI = 4'h7;
	localparam logic [3:0] TIMER_A_CONTROL = 4'he;
	localparam logic [3:0] TIMER_B_CONTROL = 4'hf;
	// ****************************************
	// control field positions
	// ****************************************
	localparam int RUN_BIT = 0;
	localparam int PORT_EN_BIT = 1;
	localparam int SHAPE_BIT = 2;
	localparam int STYLE_BIT = 3;
	localparam int LOAD_BIT = 4;
	localparam int SRC_BIT = 5;
	localparam int SHIFT_BIT = 6;
	localparam int MAINS_BIT = 7;
	localparam int SRC_B_LSB = 5;
	localparam int ALARM_BIT = 7;
	// timer b count source codes
	localparam logic [1:0] SRC_PHI2 = 2'h0;
	localparam logic [1:0] SRC_PIN = 2'h1;
	localparam logic [1:0] SRC_UFLOW = 2'h2;
	localparam logic [1:0] SRC_GATED = 2'h3;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic CTRL_BIT_RESET = 1'b0;
	localparam logic [1:0] SRC_B_RESET = 2'h0;
	localparam logic [15:0] LATCH_RESET = 16'hffff;
	localparam logic [15:0] COUNT_RESET = 16'hffff;
	localparam int IRQ_W = 5;
	localparam logic [4:0] IRQ_RESET = 5'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
endpackage

// ### rtl/dual_timer_control.sv
// control registers, counters and event logic of two 16-bit interval timers
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
// ****************************************
// Overview of operation
// RULE1 - control bit 0 starts the timer when one, stops it when zero.
// RULE2 - one-shot timer clears its own run bit on underflow.
// RULE3 - timer a control bit 1 puts timer a output on port b line six.
// RULE4 - timer b control bit 1 puts timer b output on port b line seven.
// RULE5 - bit 2 picks toggle output when one, single pulse when zero.
// RULE6 - bit 3 picks one-shot when one, continuous reload when zero.
// RULE7 - writing one to bit 4 loads the counter from its latch at once.
// RULE8 - bit 4 always reads zero; writing zero there does nothing.
// RULE9 - timer a bit 5 counts count pin rising edges, else every clock.
// RULE10 - timer a bit 6 sets serial output with count pin clock, else input.
// RULE11 - timer a bit 7 selects 50 Hz time-of-day input, else 60 Hz.
// RULE12 - timer b bits 0 to 4 act as timer a's, except the port line.
// RULE13 - timer b source 00 counts clocks, 01 counts count pin edges.
// RULE14 - source 10 counts timer a underflows, 11 only while pin high.
// RULE15 - timer b bit 7 sends time-of-day writes to alarm, else clock.
// RULE16 - unused bits ignore writes and read as zero.
// RULE17 - each timer underflow is its own interrupt source.
// RULE18 - serial output shifts at half the timer a underflow rate.
// RULE19 - load with start in one write loads first, counts next cycle.
// ****************************************

// ****************************************
// one timer: control bits 0-4, latch and counter
// ****************************************
module timer_core
	import dual_timer_pkg::*;
(
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, low active
	input wire logic ctrl_wr, // write to this control register
	input wire logic lo_wr, // write latch low byte
	input wire logic hi_wr, // write latch high byte
	input wire logic [7:0] wdata, // write data
	input wire logic tick, // qualified count source
	output logic run, // run bit
	output logic port_en, // port line routing bit
	output logic shape, // toggle when one
	output logic style, // one-shot when one
	output logic [15:0] latch, // reload value
	output logic [15:0] count, // counter
	output logic uflow, // underflow pulse
	output logic level // port line level
);
	logic toggle;
	logic pulse;
	wire load_strobe = ctrl_wr & wdata[LOAD_BIT]; // RULE7 RULE8
	// load wins over a decrement in the same cycle
	wire dec = run & tick & ~load_strobe; // RULE1 RULE19
	assign uflow = dec & (count == 16'h0000);
	assign level = shape ? toggle : pulse; // RULE5

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			run <= CTRL_BIT_RESET;
			port_en <= CTRL_BIT_RESET;
			shape <= CTRL_BIT_RESET;
			style <= CTRL_BIT_RESET;
		end
		else if (ctrl_wr)
		begin
			run <= wdata[RUN_BIT]; // RULE1
			port_en <= wdata[PORT_EN_BIT];
			shape <= wdata[SHAPE_BIT];
			style <= wdata[STYLE_BIT]; // RULE6
		end
		else if (uflow && style)
			run <= 1'b0; // RULE2
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			latch <= LATCH_RESET;
		else if (lo_wr)
			latch[7:0] <= wdata;
		else if (hi_wr)
			latch[15:8] <= wdata;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			count <= COUNT_RESET;
		else if (load_strobe)
			count <= latch; // RULE7 RULE19
		else if (uflow)
			count <= latch; // RULE6
		else if (dec)
			count <= count - 16'h0001;
	end

	// toggle output starts high on every start from stop
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			toggle <= 1'b0;
			pulse <= 1'b0;
		end
		else
		begin
			pulse <= uflow; // RULE5
			if (ctrl_wr && wdata[RUN_BIT] && !run)
				toggle <= 1'b1;
			else if (uflow)
				toggle <= ~toggle; // RULE5
		end
	end
endmodule // timer_core

// ****************************************
// top: register port, source selection, pins, interrupts
// ****************************************
module dual_timer_control
	import dual_timer_pkg::*;
(
	input wire logic mclk, // system clock, 20 MHz
	input wire logic nrst, // async reset, low active
	input wire logic [3:0] addr, // register address
	input wire logic [7:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [7:0] rdata, // read data, cycle after rd
	input wire logic count_pin_in, // count pin level, async
	output logic count_pin_out, // count pin drive value, open drain
	output logic count_pin_oe, // count pin pulled low when high
	input wire logic line_six_port_out, // ordinary port value, line six
	input wire logic line_six_port_oe, // ordinary port enable, line six
	input wire logic line_seven_port_out, // ordinary port value, line seven
	input wire logic line_seven_port_oe, // ordinary port enable, line seven
	output logic port_b_line_six_out, // line six drive value
	output logic port_b_line_six_oe, // line six drive enable
	output logic port_b_line_seven_out, // line seven drive value
	output logic port_b_line_seven_oe, // line seven drive enable
	output logic shift_direction_select, // serial port is output
	output logic serial_shift_tick, // one shift per two a underflows
	output logic mains_rate_select, // 50 Hz when high
	output logic tod_alarm_select, // time-of-day writes go to alarm
	input wire logic alarm_event, // alarm match pulse
	input wire logic serial_event, // serial byte done pulse
	input wire logic flag_event, // flag edge pulse
	output logic irq // level, unmasked status set
);
	logic a_run, a_pen, a_shape, a_style, a_uflow, a_level;
	logic b_run, b_pen, b_shape, b_style, b_uflow, b_level;
	logic [15:0] a_latch, a_count, b_latch, b_count;
	logic count_source_select;
	logic [1:0] b_source;
	logic pin_meta, pin_sync, pin_prev;
	logic shift_clk;
	logic [IRQ_W-1:0] irq_status, irq_mask;

	// ****************************************
	// address decode
	// ****************************************
	wire a_ctrl_wr = wr & (addr == TIMER_A_CONTROL);
	wire b_ctrl_wr = wr & (addr == TIMER_B_CONTROL);
	wire status_wr = wr & (addr == IRQ_STATUS);
	wire mask_wr = wr & (addr == IRQ_MASK);
	wire a_lo_wr = wr & (addr == TA_LO);
	wire a_hi_wr = wr & (addr == TA_HI);
	wire b_lo_wr = wr & (addr == TB_LO);
	wire b_hi_wr = wr & (addr == TB_HI);

	// ****************************************
	// count pin sampling
	// ****************************************
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
			pin_prev <= 1'b1;
		end
		else
		begin
			pin_meta <= count_pin_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end
	wire pin_rise = pin_sync & ~pin_prev;

	// ****************************************
	// count sources
	// ****************************************
	wire a_tick = count_source_select ? pin_rise : 1'b1; // RULE9
	wire b_tick = (b_source == SRC_PHI2) ? 1'b1 : // RULE13
		(b_source == SRC_PIN) ? pin_rise : // RULE13
		(b_source == SRC_UFLOW) ? a_uflow : // RULE14
		(a_uflow & pin_sync); // RULE14

	timer_core timer_a (
		.mclk(mclk),
		.nrst(nrst),
		.ctrl_wr(a_ctrl_wr),
		.lo_wr(a_lo_wr),
		.hi_wr(a_hi_wr),
		.wdata(wdata),
		.tick(a_tick),
		.run(a_run),
		.port_en(a_pen),
		.shape(a_shape),
		.style(a_style),
		.latch(a_latch),
		.count(a_count),
		.uflow(a_uflow),
		.level(a_level)
	);

	// same core for timer b, only source and line differ
	timer_core timer_b ( // RULE12
		.mclk(mclk),
		.nrst(nrst),
		.ctrl_wr(b_ctrl_wr),
		.lo_wr(b_lo_wr),
		.hi_wr(b_hi_wr),
		.wdata(wdata),
		.tick(b_tick),
		.run(b_run),
		.port_en(b_pen),
		.shape(b_shape),
		.style(b_style),
		.latch(b_latch),
		.count(b_count),
		.uflow(b_uflow),
		.level(b_level)
	);

	// ****************************************
	// upper control bits
	// ****************************************
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			count_source_select <= CTRL_BIT_RESET;
			shift_direction_select <= CTRL_BIT_RESET;
			mains_rate_select <= CTRL_BIT_RESET;
		end
		else if (a_ctrl_wr)
		begin
			count_source_select <= wdata[SRC_BIT]; // RULE9
			shift_direction_select <= wdata[SHIFT_BIT]; // RULE10
			mains_rate_select <= wdata[MAINS_BIT]; // RULE11
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			b_source <= SRC_B_RESET;
			tod_alarm_select <= CTRL_BIT_RESET;
		end
		else if (b_ctrl_wr)
		begin
			b_source <= wdata[SRC_B_LSB +: 2]; // RULE13 RULE14
			tod_alarm_select <= wdata[ALARM_BIT]; // RULE15
		end
	end

	// ****************************************
	// port b lines, registered
	// ****************************************
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			port_b_line_six_out <= 1'b0;
			port_b_line_six_oe <= 1'b0;
			port_b_line_seven_out <= 1'b0;
			port_b_line_seven_oe <= 1'b0;
		end
		else
		begin
			port_b_line_six_out <= a_pen ? a_level : line_six_port_out; // RULE3
			port_b_line_six_oe <= a_pen | line_six_port_oe; // RULE3
			port_b_line_seven_out <= b_pen ? b_level : line_seven_port_out; // RULE4
			port_b_line_seven_oe <= b_pen | line_seven_port_oe; // RULE4
		end
	end

	// ****************************************
	// serial shift clock from timer a
	// ****************************************
	// count pin idles high; only low half-periods are driven
	assign count_pin_out = 1'b0;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			shift_clk <= 1'b1;
			serial_shift_tick <= 1'b0;
			count_pin_oe <= 1'b0;
		end
		else
		begin
			if (!shift_direction_select)
				shift_clk <= 1'b1;
			else if (a_uflow)
				shift_clk <= ~shift_clk; // RULE18
			serial_shift_tick <= shift_direction_select & a_uflow & ~shift_clk; // RULE18
			count_pin_oe <= shift_direction_select & ~shift_clk; // RULE10
		end
	end

	// ****************************************
	// interrupt status and mask
	// ****************************************
	wire [IRQ_W-1:0] events = {flag_event, serial_event, alarm_event, b_uflow, a_uflow}; // RULE17
	wire [IRQ_W-1:0] w1c = status_wr ? wdata[IRQ_W-1:0] : IRQ_RESET;
	// a new event beats a clear arriving in the same cycle
	wire [IRQ_W-1:0] next_status = (irq_status & ~w1c) | events;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_status <= IRQ_RESET;
			irq_mask <= IRQ_RESET;
		end
		else
		begin
			irq_status <= next_status; // RULE17
			if (mask_wr)
				irq_mask <= wdata[IRQ_W-1:0];
		end
	end
	assign irq = |(irq_status & irq_mask);

	// ****************************************
	// read path
	// ****************************************
	// load bit position is always returned as zero
	wire [7:0] a_ctrl_rd = {mains_rate_select, shift_direction_select, count_source_select,
		1'b0, a_style, a_shape, a_pen, a_run}; // RULE8
	wire [7:0] b_ctrl_rd = {tod_alarm_select, b_source, 1'b0, b_style, b_shape, b_pen, b_run}; // RULE8
	wire [7:0] next_rdata = (addr == TIMER_A_CONTROL) ? a_ctrl_rd :
		(addr == TIMER_B_CONTROL) ? b_ctrl_rd :
		(addr == IRQ_STATUS) ? {3'h0, irq_status} : // RULE16
		(addr == IRQ_MASK) ? {3'h0, irq_mask} : // RULE16
		(addr == TA_LO) ? a_count[7:0] :
		(addr == TA_HI) ? a_count[15:8] :
		(addr == TB_LO) ? b_count[7:0] :
		(addr == TB_HI) ? b_count[15:8] : 8'h00; // RULE16
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			rdata <= RDATA_RESET;
		else
			rdata <= rd ? next_rdata : RDATA_RESET;
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_a_start;
		a_ctrl_wr && wdata[RUN_BIT];
	endsequence
	sequence s_load_start;
		a_ctrl_wr && wdata[LOAD_BIT] && wdata[RUN_BIT] && !wdata[SRC_BIT];
	endsequence

	property p_start;
		s_a_start |=> a_run;
	endproperty
	a_start: assert property (p_start) else $error("timer a did not start"); // RULE1
	property p_oneshot;
		a_uflow && a_style && !a_ctrl_wr |=> !a_run;
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot kept running"); // RULE2
	property p_line_six;
		a_pen |=> port_b_line_six_oe && port_b_line_six_out == $past(a_level);
	endproperty
	a_line_six: assert property (p_line_six) else $error("line six not timer a"); // RULE3
	property p_line_seven;
		b_pen |=> port_b_line_seven_oe && port_b_line_seven_out == $past(b_level);
	endproperty
	a_line_seven: assert property (p_line_seven) else $error("line seven not timer b"); // RULE4
	property p_out_shape;
		a_uflow && !a_ctrl_wr |=> (a_shape ? a_level != $past(a_level) : a_level);
	endproperty
	a_out_shape: assert property (p_out_shape) else $error("output shape wrong"); // RULE5
	property p_continuous;
		a_uflow && !a_style && !a_ctrl_wr |=> a_run && a_count == $past(a_latch);
	endproperty
	a_continuous: assert property (p_continuous) else $error("no reload"); // RULE6
	property p_load_start;
		s_load_start ##0 (a_latch != 16'h0000) ##1 !wr && !rd
			|-> a_count == $past(a_latch) ##1 a_count == $past(a_count) - 16'h0001;
	endproperty
	a_load_start: assert property (p_load_start) else $error("load then count failed"); // RULE7 RULE19
	property p_load_reads_zero;
		rd && (addr == TIMER_A_CONTROL || addr == TIMER_B_CONTROL) |=> !rdata[LOAD_BIT];
	endproperty
	a_load_reads_zero: assert property (p_load_reads_zero) else $error("load bit read one"); // RULE8
	property p_pin_source;
		a_run && count_source_select && !pin_rise && !a_ctrl_wr |=> $stable(a_count);
	endproperty
	a_pin_source: assert property (p_pin_source) else $error("counted without edge"); // RULE9
	property p_a_upper;
		a_ctrl_wr |=> shift_direction_select == $past(wdata[SHIFT_BIT])
			&& mains_rate_select == $past(wdata[MAINS_BIT]);
	endproperty
	a_a_upper: assert property (p_a_upper) else $error("upper bits not stored"); // RULE10 RULE11
	property p_gated;
		b_run && b_source == SRC_GATED && !pin_sync && !b_ctrl_wr |=> $stable(b_count);
	endproperty
	a_gated: assert property (p_gated) else $error("gated count while pin low"); // RULE14
	property p_alarm_sel;
		b_ctrl_wr |=> tod_alarm_select == $past(wdata[ALARM_BIT]);
	endproperty
	a_alarm_sel: assert property (p_alarm_sel) else $error("alarm select not stored"); // RULE15
	property p_unmapped;
		rd && addr inside {4'h2, 4'h3, [4'h8:4'hd]} |=> rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // RULE16
	property p_irq_set;
		b_uflow |=> irq_status[1];
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("timer b flag lost"); // RULE17
	property p_uflow_flags;
		a_uflow |=> irq_status[0];
	endproperty
	a_uflow_flags: assert property (p_uflow_flags) else $error("underflow flag lost"); // RULE17
	property p_shift_rate;
		serial_shift_tick |-> $past(a_uflow) && $past(shift_clk) == 1'b0;
	endproperty
	a_shift_rate: assert property (p_shift_rate) else $error("shift tick off rate"); // RULE18
endmodule // dual_timer_control

// ### testbench/tb_dual_timer_control.sv
// self-checking bench for the dual interval timer control block
`timescale 1ns/1ps
module tb_dual_timer_control;
	import dual_timer_pkg::*;
	// ****************************************
	// signals and design instance
	// ****************************************
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic count_pin_in = 1'b0;
	logic line_six_port_out = 1'b1;
	logic line_six_port_oe = 1'b0;
	logic line_seven_port_out = 1'b0;
	logic line_seven_port_oe = 1'b1;
	logic alarm_event = 1'b0;
	logic serial_event = 1'b0;
	logic flag_event = 1'b0;
	logic [7:0] rdata;
	logic count_pin_out, count_pin_oe, irq;
	logic port_b_line_six_out, port_b_line_six_oe, port_b_line_seven_out, port_b_line_seven_oe;
	logic shift_direction_select, serial_shift_tick, mains_rate_select, tod_alarm_select;
	int n_mismatch = 0;
	int check_count = 0;
	int h6, h7, ht, ho;

	always #25 mclk = ~mclk;

	dual_timer_control dual_timer_control_i (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .count_pin_in(count_pin_in),
		.count_pin_out(count_pin_out), .count_pin_oe(count_pin_oe),
		.line_six_port_out(line_six_port_out), .line_six_port_oe(line_six_port_oe),
		.line_seven_port_out(line_seven_port_out), .line_seven_port_oe(line_seven_port_oe),
		.port_b_line_six_out(port_b_line_six_out), .port_b_line_six_oe(port_b_line_six_oe),
		.port_b_line_seven_out(port_b_line_seven_out), .port_b_line_seven_oe(port_b_line_seven_oe),
		.shift_direction_select(shift_direction_select), .serial_shift_tick(serial_shift_tick),
		.mains_rate_select(mains_rate_select), .tod_alarm_select(tod_alarm_select),
		.alarm_event(alarm_event), .serial_event(serial_event), .flag_event(flag_event),
		.irq(irq));

	// ****************************************
	// access and compare tasks
	// ****************************************
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string name);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		check(name, exp, rdata);
	endtask

	// counts high cycles of the port lines, shift tick and count pin drive
	task automatic watch(input int n, output int c6, output int c7, output int ct, output int co);
		c6 = 0;
		c7 = 0;
		ct = 0;
		co = 0;
		repeat (n)
		begin
			@(posedge mclk);
			#1;
			if (port_b_line_six_out === 1'b1) c6++;
			if (port_b_line_seven_out === 1'b1) c7++;
			if (serial_shift_tick === 1'b1) ct++;
			if (count_pin_oe === 1'b1) co++;
		end
	endtask

	// pin goes through a two-stage synchroniser, so each level is held several cycles
	task automatic pin_edge;
		@(posedge mclk);
		count_pin_in <= 1'b1;
		repeat (4) @(posedge mclk);
		count_pin_in <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	task automatic pulse_ev(input int k);
		@(posedge mclk);
		alarm_event <= (k == 0);
		serial_event <= (k == 1);
		flag_event <= (k == 2);
		@(posedge mclk);
		{alarm_event, serial_event, flag_event} <= 3'h0;
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ****************************************
	// watchdog: the sequence needs well under 2000 cycles
	// ****************************************
	initial
	begin
		#(50 * 20000);
		n_mismatch++;
		end_sim();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial
	begin
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		rd_chk(TIMER_A_CONTROL, 8'h00, "ctrl_a_reset");
		rd_chk(TIMER_B_CONTROL, 8'h00, "ctrl_b_reset");
		rd_chk(TA_LO, 8'hff, "count_a_reset");
		rd_chk(TB_HI, 8'hff, "count_b_reset");
		check("six_ordinary", 8'h01, {7'h0, port_b_line_six_out});
		check("six_oe_ordinary", 8'h00, {7'h0, port_b_line_six_oe});
		// one-shot with load and start in the same write
		wr_reg(TA_LO, 8'h02);
		wr_reg(TA_HI, 8'h00);
		wr_reg(TIMER_A_CONTROL, 8'h19);
		repeat (10) @(posedge mclk);
		rd_chk(TIMER_A_CONTROL, 8'h08, "ctrl_a_oneshot_done");
		rd_chk(TA_LO, 8'h02, "count_a_stopped");
		rd_chk(IRQ_STATUS, 8'h01, "status_a_uflow");
		// latch writes alone never reach a stopped counter; only the strobe does
		wr_reg(TA_LO, 8'h05);
		rd_chk(TA_LO, 8'h02, "count_a_no_load");
		wr_reg(TIMER_A_CONTROL, 8'h18);
		rd_chk(TIMER_A_CONTROL, 8'h08, "load_reads_zero");
		rd_chk(TA_LO, 8'h05, "count_a_forced");
		wr_reg(TA_LO, 8'h07);
		wr_reg(TIMER_A_CONTROL, 8'h08);
		rd_chk(TA_LO, 8'h05, "load_zero_inert");
		// port line six: pulse then toggle
		wr_reg(TIMER_A_CONTROL, 8'h1b);
		watch(20, h6, h7, ht, ho);
		check("six_pulse_cycles", 8'h01, 8'(h6));
		check("six_oe_routed", 8'h01, {7'h0, port_b_line_six_oe});
		wr_reg(TIMER_A_CONTROL, 8'h1f);
		watch(20, h6, h7, ht, ho);
		check("six_toggle_long", 8'h01, {7'h0, h6 > 2});
		check("six_toggle_end", 8'h00, {7'h0, port_b_line_six_out});
		// timer b on line seven
		wr_reg(TB_LO, 8'h03);
		wr_reg(TB_HI, 8'h00);
		wr_reg(TIMER_B_CONTROL, 8'h1b);
		watch(20, h6, h7, ht, ho);
		check("seven_pulse_cycles", 8'h01, 8'(h7));
		rd_chk(TIMER_B_CONTROL, 8'h0a, "ctrl_b_oneshot_done");
		rd_chk(IRQ_STATUS, 8'h03, "status_b_uflow");
		line_seven_port_out <= 1'b1;
		wr_reg(TIMER_B_CONTROL, 8'h00);
		repeat (2) @(posedge mclk);
		#1;
		check("seven_ordinary", 8'h03, {6'h0, port_b_line_seven_out, port_b_line_seven_oe});
		// count pin source for both timers: second edge underflows from one
		wr_reg(TA_LO, 8'h01);
		wr_reg(TB_LO, 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			wr_reg(i ? TIMER_B_CONTROL : TIMER_A_CONTROL, 8'h39);
			repeat (20) @(posedge mclk);
			rd_chk(i ? TIMER_B_CONTROL : TIMER_A_CONTROL, 8'h29, "pin_src_idle");
			pin_edge();
			rd_chk(i ? TIMER_B_CONTROL : TIMER_A_CONTROL, 8'h29, "pin_src_one");
			pin_edge();
			rd_chk(i ? TIMER_B_CONTROL : TIMER_A_CONTROL, 8'h28, "pin_src_two");
		end
		// timer b counting timer a underflows, plain and gated
		wr_reg(TIMER_A_CONTROL, 8'h00);
		wr_reg(TIMER_B_CONTROL, 8'h59);
		repeat (20) @(posedge mclk);
		rd_chk(TIMER_B_CONTROL, 8'h49, "uflow_src_idle");
		wr_reg(TIMER_A_CONTROL, 8'h11);
		repeat (10) @(posedge mclk);
		rd_chk(TIMER_B_CONTROL, 8'h48, "uflow_src_done");
		wr_reg(TIMER_B_CONTROL, 8'h79);
		repeat (20) @(posedge mclk);
		rd_chk(TIMER_B_CONTROL, 8'h69, "gated_src_low");
		count_pin_in <= 1'b1;
		repeat (20) @(posedge mclk);
		rd_chk(TIMER_B_CONTROL, 8'h68, "gated_src_high");
		count_pin_in <= 1'b0;
		// serial output mode: shift clock at half the underflow rate
		wr_reg(TIMER_A_CONTROL, 8'h53);
		watch(40, h6, h7, ht, ho);
		check("shift_dir_out", 8'h01, {7'h0, shift_direction_select});
		check("shift_half_rate", 8'h01, {7'h0, ht > 0 && h6 >= 2 * ht - 1 && h6 <= 2 * ht + 1});
		check("count_pin_driven", 8'h01, {7'h0, ho > 0});
		check("count_pin_low", 8'h00, {7'h0, count_pin_out});
		wr_reg(TIMER_A_CONTROL, 8'h80);
		rd_chk(TIMER_A_CONTROL, 8'h80, "ctrl_a_mains");
		check("mains_shift", 8'h02, {6'h0, mains_rate_select, shift_direction_select});
		wr_reg(TIMER_B_CONTROL, 8'h80);
		#1;
		check("alarm_select", 8'h01, {7'h0, tod_alarm_select});
		wr_reg(TIMER_B_CONTROL, 8'h00);
		#1;
		check("clock_select", 8'h00, {7'h0, tod_alarm_select});
		// interrupts: sticky status, mask, write-one clear
		wr_reg(TIMER_A_CONTROL, 8'h00);
		wr_reg(IRQ_STATUS, 8'h1f);
		rd_chk(IRQ_STATUS, 8'h00, "status_cleared");
		for (int k = 0; k < 3; k++) pulse_ev(k);
		rd_chk(IRQ_STATUS, 8'h1c, "status_events");
		check("irq_masked", 8'h00, {7'h0, irq});
		wr_reg(IRQ_MASK, 8'h04);
		#1;
		check("irq_unmasked", 8'h01, {7'h0, irq});
		wr_reg(IRQ_STATUS, 8'h04);
		#1;
		check("irq_cleared", 8'h00, {7'h0, irq});
		rd_chk(IRQ_STATUS, 8'h18, "status_partial");
		rd_chk(IRQ_MASK, 8'h04, "mask_readback");
		wr_reg(4'h3, 8'hff);
		rd_chk(4'h3, 8'h00, "unmapped_read");
		end_sim();
	end
endmodule // tb_dual_timer_control
